// ---- lamp_defines.svh ----
// Timing constants for the drive activity lamp logic.
// Assumes a 100 MHz system clock.
`ifndef LAMP_DEFINES_SVH
`define LAMP_DEFINES_SVH

`define SYS_CLK_HZ         100000000
`define BLINK_HALF_MS      500
`define BLINK_HALF_CYCLES  ((`SYS_CLK_HZ / 1000) * `BLINK_HALF_MS)
`define LAMP_PAGE_CODE     8'h19

`endif

// ---- lamp_pkg.sv ----
// Types shared by the drive activity lamp logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lamp_pkg;

	typedef enum logic [1:0] {
		SPIN_DOWN,
		SPIN_UP,
		SPIN_MOVING
	} spindle_e;

	typedef struct packed {
		spindle_e spindle;
		logic     cmdActive;
		logic     formatActive;
		logic     cylinderStep;
	} drive_cond_s;

endpackage : lamp_pkg
`default_nettype wire

// ---- drive_activity_lamp_logic.sv ----
// Drive activity lamp: maps firmware conditions to an open-drain lamp pin.
// Assumes conditions arrive from logic on sys_clk; cylinderStep is a one-cycle pulse.
`include "lamp_defines.svh"
`default_nettype none

module drive_activity_lamp_logic #(
	parameter int unsigned HALF_PERIOD = `BLINK_HALF_CYCLES
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire lamp_pkg::drive_cond_s cond,
	input  wire logic                 lamp_polarity_select,
	input  wire logic                 indicator_lamp_drive_in,
	output logic                      indicator_lamp_drive_out,
	output logic                      indicator_lamp_drive_oe_n
);
	import lamp_pkg::*;

	localparam int CW = $clog2(HALF_PERIOD + 1);
	// Last count of a half period; the counter wraps here and the blink phase flips
	localparam logic [CW-1:0] LAST_TICK = CW'(HALF_PERIOD - 1);

	////////////////////////////////////////////////////////////////////////////
	// State
	logic          pinMeta_r, pinMeta_nxt;
	logic          pinSync_r, pinSync_nxt;
	logic [CW-1:0] blinkCnt_r, blinkCnt_nxt;
	logic          blinkLit_r, blinkLit_nxt;
	logic          moving_r, moving_nxt;
	logic          fmtLamp_r, fmtLamp_nxt;
	logic          fmtWas_r, fmtWas_nxt;
	logic          lampOn_r, lampOn_nxt;
	logic          oeN_nxt;
	logic          pinData_nxt;
	logic          mapLamp;
	logic          moving;
	logic          blinkStart;
	logic          fmtStart;
	logic          fmtBase;

	////////////////////////////////////////////////////////////////////////////
	// Pin readback
	// The pin lives outside sys_clk, so it passes two flops before anything reads it
	always_comb begin
		pinMeta_nxt = indicator_lamp_drive_in;
		pinSync_nxt = pinMeta_r;
	end

	// Reset to the released level so no false low is seen after reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pinMeta_r <= 1'b1;
			pinSync_r <= 1'b1;
		end else begin
			pinMeta_r <= pinMeta_nxt;
			pinSync_r <= pinSync_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Condition mapping
	assign moving = (cond.spindle == SPIN_MOVING);

	// Spindle code 3 is unused and shows dark rather than a guessed mapping
	always_comb begin
		unique case (cond.spindle)
			SPIN_DOWN: mapLamp = cond.cmdActive;
			SPIN_UP:   mapLamp = cond.cmdActive ~^ lamp_polarity_select;
			default:   mapLamp = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Transition blink
	assign blinkStart = moving && !moving_r;

	always_comb begin
		moving_nxt   = moving;
		blinkCnt_nxt = blinkCnt_r;
		blinkLit_nxt = blinkLit_r;
		if (blinkStart) begin
			// Restart so each transition opens with a full lit half-period
			blinkCnt_nxt = '0;
			blinkLit_nxt = 1'b1;
		end else if (moving) begin
			if (blinkCnt_r == LAST_TICK) begin
				blinkCnt_nxt = '0;
				blinkLit_nxt = ~blinkLit_r;
			end else begin
				blinkCnt_nxt = blinkCnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			blinkCnt_r <= '0;
			blinkLit_r <= 1'b0;
			moving_r   <= 1'b0;
		end else begin
			blinkCnt_r <= blinkCnt_nxt;
			blinkLit_r <= blinkLit_nxt;
			moving_r   <= moving_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Format toggling
	assign fmtStart = cond.formatActive && !fmtWas_r;
	// Toggling starts from what the lamp shows at entry, so a format start causes no jump
	assign fmtBase = fmtStart ? lampOn_r : fmtLamp_r;

	always_comb begin
		fmtWas_nxt  = cond.formatActive;
		fmtLamp_nxt = fmtLamp_r;
		if (cond.formatActive) begin
			if (cond.cylinderStep)
				fmtLamp_nxt = ~fmtBase;
			else
				fmtLamp_nxt = fmtBase;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fmtLamp_r <= 1'b0;
			fmtWas_r  <= 1'b0;
		end else begin
			fmtLamp_r <= fmtLamp_nxt;
			fmtWas_r  <= fmtWas_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Lamp and pin
	always_comb begin
		if (cond.formatActive)
			lampOn_nxt = fmtLamp_nxt;
		else if (moving)
			lampOn_nxt = blinkLit_nxt;
		else
			lampOn_nxt = mapLamp;
		// Data stays low and only the enable moves, so the pin never drives high
		oeN_nxt     = ~lampOn_nxt;
		pinData_nxt = 1'b0;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lampOn_r                  <= 1'b0;
			indicator_lamp_drive_oe_n <= 1'b1;
			indicator_lamp_drive_out  <= 1'b0;
		end else begin
			lampOn_r                  <= lampOn_nxt;
			indicator_lamp_drive_oe_n <= oeN_nxt;
			indicator_lamp_drive_out  <= pinData_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Pin level
	odrain_low_a: assert property (indicator_lamp_drive_out == 1'b0) else $error("lamp pin driven high");
	enable_tracks_a: assert property ((cond.spindle == SPIN_DOWN && cond.cmdActive && !cond.formatActive)
		|=> !indicator_lamp_drive_oe_n) else $error("pin not pulled low while stopped and busy");
	lamp_dark_a: assert property ((cond.spindle == SPIN_DOWN && !cond.cmdActive && !cond.formatActive)
		|=> indicator_lamp_drive_oe_n) else $error("pin pulled low while stopped and idle");

	// Mapping
	down_idle_a: assert property ((cond.spindle == SPIN_DOWN && !cond.cmdActive && !cond.formatActive)
		|=> !lampOn_r) else $error("lamp lit while stopped and idle");
	down_busy_a: assert property ((cond.spindle == SPIN_DOWN && cond.cmdActive && !cond.formatActive)
		|=> lampOn_r) else $error("lamp dark while stopped and busy");
	up_idle_a: assert property ((cond.spindle == SPIN_UP && !cond.cmdActive && !cond.formatActive)
		|=> lampOn_r == !$past(lamp_polarity_select)) else $error("spun-up idle mapping wrong");
	up_busy_a: assert property ((cond.spindle == SPIN_UP && cond.cmdActive && !cond.formatActive)
		|=> lampOn_r == $past(lamp_polarity_select)) else $error("spun-up busy mapping wrong");
	sel_polarity_a: assert property ((cond.spindle == SPIN_UP && $past(cond.spindle) == SPIN_UP
		&& !cond.formatActive && !$past(cond.formatActive)
		&& $changed(lamp_polarity_select) && $stable(cond.cmdActive))
		|=> $changed(lampOn_r)) else $error("polarity select ignored");

	// Blink
	blink_start_a: assert property ((moving && !moving_r && !cond.formatActive) |=> lampOn_r)
		else $error("blink not lit first");
	blink_edge_a: assert property ((moving && moving_r && blinkCnt_r == LAST_TICK
		&& !cond.formatActive) |=> lampOn_r != $past(blinkLit_r)) else $error("blink did not flip");
	blink_hold_a: assert property ((moving && moving_r && blinkCnt_r != LAST_TICK
		&& !cond.formatActive && !$past(cond.formatActive)) |=> $stable(lampOn_r))
		else $error("blink moved mid half-period");

	// Format
	fmt_entry_a: assert property ((fmtStart && !cond.cylinderStep) |=> $stable(lampOn_r))
		else $error("format entry moved the lamp");
	fmt_toggle_a: assert property ((cond.formatActive && fmtWas_r && cond.cylinderStep)
		|=> lampOn_r != $past(lampOn_r)) else $error("format step did not toggle");
	fmt_hold_a: assert property ((cond.formatActive && fmtWas_r && !cond.cylinderStep)
		|=> $stable(lampOn_r)) else $error("format lamp moved without step");

	// Scenario covers
	blink_cov: cover property (moving_r && blinkCnt_r == LAST_TICK);
	fmt_cov: cover property (cond.formatActive && cond.cylinderStep);
	up_busy_cov: cover property (cond.spindle == SPIN_UP && cond.cmdActive && lamp_polarity_select);
	down_busy_cov: cover property (cond.spindle == SPIN_DOWN && cond.cmdActive);
	pin_low_cov: cover property (!indicator_lamp_drive_oe_n && !pinSync_r);

endmodule : drive_activity_lamp_logic
`default_nettype wire

// ---- lamp_model.sv ----
// Lamp and resistor on the open-drain lamp pin.
// Assumes the enable is active low and the pin has a pull-up.
`default_nettype none
module lamp_model (
	input  wire logic oeN,
	input  wire logic drv,
	output logic      pin,
	output logic      lit
);
	timeunit 1ns;
	timeprecision 1ns;
	// A released pin goes to the pull-up level, never the last driven value
	assign pin = oeN ? 1'b1 : drv;
	assign lit = ~pin;
endmodule : lamp_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the drive activity lamp logic.
// Assumes lamp_model on the pin and a short blink half period.
`default_nettype none
module testbench;
	import lamp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HP = 8;
	logic        sysClk, rst, pol, pin, lit, drvOut, oeN;
	drive_cond_s cond;
	int          nFail = 0;
	int          samplesChecked = 0;
	drive_activity_lamp_logic #(.HALF_PERIOD(HP)) drive_activity_lamp_logic_i (.sys_clk(sysClk), .rst(rst),
		.cond(cond), .lamp_polarity_select(pol), .indicator_lamp_drive_in(pin),
		.indicator_lamp_drive_out(drvOut), .indicator_lamp_drive_oe_n(oeN));
	lamp_model lamp_model_i (.oeN(oeN), .drv(drvOut), .pin(pin), .lit(lit));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic seen, input logic exp);
		samplesChecked++;
		if (seen !== exp) begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic step(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask : step
	task automatic reportAndStop();
		if (nFail == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : reportAndStop
	////////////////////////////////////////////////////////////////////////
	task automatic map_test();
		for (int i = 0; i < 8; i++) begin
			pol = i[2];
			cond.spindle = i[1] ? SPIN_UP : SPIN_DOWN;
			cond.cmdActive = i[0];
			step(1);
			chk(lit, i[1] ? (i[0] ^ ~i[2]) : i[0]);
		end
	endtask : map_test
	// Polarity flips while spun up and idle must leave the lamp at the inverse of the select each time
	task automatic polarity_test();
		cond.spindle = SPIN_UP;
		cond.cmdActive = 1'b0;
		for (int i = 0; i < 4; i++) begin
			pol = i[0];
			step(1);
			chk(lit, ~i[0]);
		end
	endtask : polarity_test
	task automatic reset_test();
		rst = 1'b1;
		pol = 1'b0;
		cond = '0;
		step(6);
		chk(oeN, 1'b1);
		chk(drvOut, 1'b0);
		rst = 1'b0;
		step(1);
		chk(lit, 1'b0);
	endtask : reset_test
	// Parks the spindle first so every call enters the transition afresh
	task automatic blink_test(input int n);
		cond.cmdActive = 1'b0;
		cond.spindle = SPIN_DOWN;
		step(1);
		chk(lit, 1'b0);
		cond.spindle = SPIN_MOVING;
		for (int i = 0; i < n; i++) begin
			step(1);
			chk(lit, ((i / HP) % 2) == 0);
		end
	endtask : blink_test
	// Entered right where the blink would go dark, so the hold shows priority
	task automatic format_test();
		logic held;
		held = 1'b1;
		cond.formatActive = 1'b1;
		step(HP);
		chk(lit, held);
		for (int i = 0; i < 4; i++) begin
			cond.cylinderStep = 1'b1;
			step(1);
			held = ~held;
			chk(lit, held);
		end
		cond.cylinderStep = 1'b0;
		step(2);
		chk(lit, held);
		chk(oeN, 1'b0);
		chk(drvOut, 1'b0);
	endtask : format_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		sysClk = 1'b0;
		forever #5 sysClk = ~sysClk;
	end
	initial begin
		#20000;
		nFail++;
		reportAndStop();
	end
	initial begin
		reset_test();
		map_test();
		polarity_test();
		blink_test(12);
		blink_test(24);
		format_test();
		// Mid-run reset while the lamp is lit must leave the pin released six clocks into reset
		reset_test();
		reportAndStop();
	end
endmodule : testbench
`default_nettype wire
